// >>> rtl/das_core.sv
// Data-space access path: lanes, alignment, near addressing, stack check
`timescale 1ns/10ps
`default_nettype none
`include "das_params.svh"
module das_core (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                acc_valid,
    input  wire das_pkg::das_mode_t  acc_mode,
    input  wire logic                acc_write,
    input  wire logic                acc_byte,
    input  wire logic [3:0]          acc_ptr_sel,
    input  wire logic                acc_post_inc,
    input  wire logic                acc_pre_dec,
    input  wire logic [15:0]         acc_direct_addr,
    input  wire logic [15:0]         acc_wdata,
    input  wire logic                acc_load,
    input  wire logic [3:0]          acc_dest_sel,
    input  wire das_pkg::das_pcpush_t acc_pc_push,
    input  wire logic [6:0]          pc_upper,
    input  wire logic [7:0]          status_low_byte,
    input  wire logic                ext_valid,
    input  wire logic                sign_extend_op,
    input  wire logic [3:0]          ext_reg_sel,
    input  wire logic                y_valid,
    input  wire logic [3:0]          y_ptr_sel,
    output logic [15:0]              mem_addr,
    output logic                     mem_re,
    output logic                     mem_we_lo,
    output logic                     mem_we_hi,
    output logic [15:0]              mem_wdata,
    input  wire logic [15:0]         mem_rdata,
    input  wire logic                mem_hit,
    output logic [15:0]              ymem_addr,
    output logic                     ymem_re,
    input  wire logic [15:0]         ymem_rdata,
    input  wire logic                ymem_hit,
    output logic [15:0]              x_rdata,
    output logic                     x_rvalid,
    output logic [15:0]              y_rdata,
    output logic                     y_rvalid,
    output logic [15:0]              effective_address,
    output logic [15:0]              stack_pointer,
    output logic                     trap_req,
    output das_pkg::das_cause_t      trap_cause
);
    import das_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    localparam logic [15:0] WOFS [16] = '{
        `DAS_W0_OFS,
        `DAS_W1_OFS,
        `DAS_W2_OFS,
        `DAS_W3_OFS,
        `DAS_W4_OFS,
        `DAS_W5_OFS,
        `DAS_W6_OFS,
        `DAS_W7_OFS,
        `DAS_W8_OFS,
        `DAS_W9_OFS,
        `DAS_W10_OFS,
        `DAS_W11_OFS,
        `DAS_W12_OFS,
        `DAS_W13_OFS,
        `DAS_W14_OFS,
        `DAS_W15_OFS
    };

    logic [15:0]    wreg [16];
    logic [15:0]    stack_limit_reg;
    logic [15:0]    x_rdata_reg;
    logic           x_rvalid_reg;
    logic [15:0]    y_rdata_reg;
    logic           y_rvalid_reg;
    logic           trap_reg;
    das_cause_t     cause_reg;

    // ----------------------------------------------------------------
    // Address generation
    // ----------------------------------------------------------------
    logic [15:0]    ptr_val;
    logic [15:0]    step;
    logic [15:0]    ea;
    logic [15:0]    ptr_next;
    logic           ptr_upd;
    logic [3:0]     ptr_idx;
    logic           is_word;
    logic           uses_sp;

    assign is_word = ~acc_byte || acc_mode == das_mode_push
                     || acc_mode == das_mode_pop;
    assign step = is_word ? `DAS_STEP_WORD : `DAS_STEP_BYTE;

    always_comb begin
        ptr_idx  = acc_ptr_sel;
        ptr_val  = wreg[acc_ptr_sel];
        ea       = ptr_val;
        ptr_next = ptr_val;
        ptr_upd  = 1'b0;
        unique case (acc_mode)
            das_mode_indirect: begin
                if (acc_pre_dec) begin
                    ea       = ptr_val - step;
                    ptr_next = ptr_val - step;
                    ptr_upd  = 1'b1;
                end else if (acc_post_inc) begin
                    ptr_next = ptr_val + step;
                    ptr_upd  = 1'b1;
                end
            end
            das_mode_near: begin
                ea = acc_direct_addr & `DAS_NEAR_MASK;
            end
            das_mode_move: begin
                ea = acc_direct_addr;
            end
            das_mode_push: begin
                ptr_idx  = `DAS_SP_INDEX;
                ptr_val  = wreg[`DAS_SP_INDEX];
                ea       = ptr_val;
                ptr_next = ptr_val + `DAS_STEP_WORD;
                ptr_upd  = 1'b1;
            end
            das_mode_pop: begin
                ptr_idx  = `DAS_SP_INDEX;
                ptr_val  = wreg[`DAS_SP_INDEX];
                ea       = ptr_val - `DAS_STEP_WORD;
                ptr_next = ptr_val - `DAS_STEP_WORD;
                ptr_upd  = 1'b1;
            end
            default: begin
                ea = ptr_val;
            end
        endcase
    end

    assign uses_sp = acc_mode == das_mode_push || acc_mode == das_mode_pop
                     || (acc_mode == das_mode_indirect
                         && acc_ptr_sel == `DAS_SP_INDEX);

    // ----------------------------------------------------------------
    // Error detection
    // ----------------------------------------------------------------
    logic misalign;
    logic stack_err;
    logic over_limit;
    logic under_floor;

    assign misalign = acc_valid && is_word && ea[0];
    // Limit test passes at equality, so a push landing on the limit is legal
    assign over_limit  = ea > stack_limit_reg;
    assign under_floor = ea < `DAS_SP_FLOOR;
    assign stack_err = acc_valid && uses_sp
                       && (over_limit || under_floor);

    // ----------------------------------------------------------------
    // Register map decode
    // ----------------------------------------------------------------
    logic [15:0]    reg_hit_vec;
    logic           reg_hit;
    logic [3:0]     reg_idx;
    logic           lim_hit;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_dec
            assign reg_hit_vec[gi] = ea[15:1] == WOFS[gi][15:1];
        end
    endgenerate

    // Lowest index wins where two entries share a word
    always_comb begin
        reg_hit = 1'b0;
        reg_idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (reg_hit_vec[i]) begin
                reg_hit = 1'b1;
                reg_idx = 4'(i);
            end
        end
    end

    assign lim_hit = ea[15:1] == `DAS_STACK_LIMIT_REG_OFS >> 1;

    // ----------------------------------------------------------------
    // Write data and lanes
    // ----------------------------------------------------------------
    logic [15:0]    wdata;
    logic           wr_ok;
    logic           we_lo;
    logic           we_hi;

    always_comb begin
        unique case (acc_pc_push)
            das_pcpush_call: wdata = {8'h00, 1'b0, pc_upper};
            das_pcpush_excp: wdata = {status_low_byte, 1'b0, pc_upper};
            das_pcpush_none: wdata = is_word ? acc_wdata
                                     : {acc_wdata[7:0], acc_wdata[7:0]};
            default:         wdata = acc_wdata;
        endcase
    end

    // Misaligned store still runs the instruction, only the store is dropped
    assign wr_ok = acc_valid && acc_write && !misalign;
    assign we_lo = wr_ok && (is_word || !ea[0]);
    assign we_hi = wr_ok && (is_word || ea[0]);

    assign mem_addr  = ea;
    assign mem_wdata = wdata;
    assign mem_re    = acc_valid && !acc_write && !reg_hit && !lim_hit;
    assign mem_we_lo = we_lo && !reg_hit && !lim_hit;
    assign mem_we_hi = we_hi && !reg_hit && !lim_hit;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [15:0]    rd_word;
    logic [15:0]    rd_x;

    always_comb begin
        if (reg_hit) begin
            rd_word = wreg[reg_idx];
        end else if (lim_hit) begin
            rd_word = stack_limit_reg;
        end else if (mem_hit) begin
            rd_word = mem_rdata;
        end else begin
            rd_word = 16'h0000;
        end
    end

    // Whole word is fetched, then one byte picked and zero-filled above
    assign rd_x = is_word ? rd_word
                  : ea[0] ? {8'h00, rd_word[15:8]}
                  : {8'h00, rd_word[7:0]};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            x_rdata_reg  <= 16'h0000;
            x_rvalid_reg <= 1'b0;
        end else begin
            x_rvalid_reg <= acc_valid && !acc_write;
            if (acc_valid && !acc_write) begin
                x_rdata_reg <= rd_x;
            end
        end
    end

    // ----------------------------------------------------------------
    // Y read path, words only
    // ----------------------------------------------------------------
    assign ymem_addr = {wreg[y_ptr_sel][15:1], 1'b0};
    assign ymem_re   = y_valid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            y_rdata_reg  <= 16'h0000;
            y_rvalid_reg <= 1'b0;
        end else begin
            y_rvalid_reg <= y_valid;
            if (y_valid) begin
                y_rdata_reg <= ymem_hit ? ymem_rdata : 16'h0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Working registers
    // ----------------------------------------------------------------
    logic [15:0]    ld_val;
    logic [15:0]    ext_val;
    logic           ld_en;

    assign ld_val = is_word ? rd_word
                    : {wreg[acc_dest_sel][15:8], rd_x[7:0]};
    assign ext_val = sign_extend_op
                     ? {{8{wreg[ext_reg_sel][7]}}, wreg[ext_reg_sel][7:0]}
                     : {8'h00, wreg[ext_reg_sel][7:0]};
    assign ld_en = acc_valid && acc_load && !acc_write;

    // One register per entry; later sources take precedence within a cycle
    generate
        for (gi = 0; gi < 16; gi++) begin : g_wreg
            logic   upd_hit;
            logic   map_hit;
            logic   ld_hit;
            logic   ext_hit;

            assign upd_hit = acc_valid && ptr_upd && ptr_idx == 4'(gi);
            assign map_hit = reg_hit && reg_idx == 4'(gi);
            assign ld_hit  = ld_en && acc_dest_sel == 4'(gi);
            assign ext_hit = ext_valid && ext_reg_sel == 4'(gi);

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    wreg[gi] <= (gi == 15) ? `DAS_SP_RST : `DAS_WREG_RST;
                end else begin
                    if (upd_hit) begin
                        wreg[gi] <= ptr_next;
                    end
                    if (map_hit && we_lo) begin
                        wreg[gi][7:0] <= wdata[7:0];
                    end
                    if (map_hit && we_hi) begin
                        wreg[gi][15:8] <= wdata[15:8];
                    end
                    if (ld_hit) begin
                        wreg[gi] <= ld_val;
                    end
                    if (ext_hit) begin
                        wreg[gi] <= ext_val;
                    end
                    // Stack pointer stays word aligned whatever is written to it
                    if (gi == 15) begin
                        wreg[gi][0] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Stack limit
    // ----------------------------------------------------------------
    // No reset: software must load it before relying on the limit check
    always_ff @(posedge ref_clk) begin
        if (lim_hit && we_lo) begin
            stack_limit_reg[7:1] <= wdata[7:1];
        end
        if (lim_hit && we_hi) begin
            stack_limit_reg[15:8] <= wdata[15:8];
        end
        stack_limit_reg[0] <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Trap request
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trap_reg  <= 1'b0;
            cause_reg <= das_cause_none;
        end else begin
            trap_reg <= misalign || stack_err;
            if (misalign) begin
                cause_reg <= das_cause_addr;
            end else if (stack_err) begin
                cause_reg <= das_cause_stack;
            end else begin
                cause_reg <= das_cause_none;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign x_rdata           = x_rdata_reg;
    assign x_rvalid          = x_rvalid_reg;
    assign y_rdata           = y_rdata_reg;
    assign y_rvalid          = y_rvalid_reg;
    assign effective_address = ea;
    assign stack_pointer     = wreg[15];
    assign trap_req          = trap_reg;
    assign trap_cause        = cause_reg;

endmodule
`default_nettype wire

// >>> rtl/das_params.svh
// Constants for the data access, alignment and stack check block
`ifndef DAS_PARAMS_SVH
`define DAS_PARAMS_SVH
`define DAS_W0_OFS     16'h0000
`define DAS_W1_OFS     16'h0005
`define DAS_W2_OFS     16'h0004
`define DAS_W3_OFS     16'h9000
`define DAS_W4_OFS     16'h8000
`define DAS_W5_OFS     16'h000a
`define DAS_W6_OFS     16'hd000
`define DAS_W7_OFS     16'h3000
`define DAS_W8_OFS     16'h0010
`define DAS_W9_OFS     16'h0012
`define DAS_W10_OFS    16'h0014
`define DAS_W11_OFS    16'h0016
`define DAS_W12_OFS    16'h0018
`define DAS_W13_OFS    16'h001a
`define DAS_W14_OFS    16'h001c
`define DAS_W15_OFS    16'h001e
`define DAS_STACK_LIMIT_REG_OFS  16'h0020
`define DAS_WREG_RST   16'h0000
`define DAS_SP_RST     16'h0800
`define DAS_SP_FLOOR   16'h0800
`define DAS_NEAR_MASK  16'h1fff
`define DAS_STEP_BYTE  16'h0001
`define DAS_STEP_WORD  16'h0002
`define DAS_SP_INDEX   4'hf
`endif

// >>> rtl/das_pkg.sv
// Types for the data access, alignment and stack check block
package das_pkg;
    typedef enum logic [2:0] {
        das_mode_indirect = 3'b000,
        das_mode_near     = 3'b001,
        das_mode_move     = 3'b010,
        das_mode_push     = 3'b011,
        das_mode_pop      = 3'b100
    } das_mode_t;
    typedef enum logic [1:0] {
        das_pcpush_none  = 2'b00,
        das_pcpush_call  = 2'b01,
        das_pcpush_excp  = 2'b10
    } das_pcpush_t;
    typedef enum logic [1:0] {
        das_cause_none  = 2'b00,
        das_cause_addr  = 2'b01,
        das_cause_stack = 2'b10
    } das_cause_t;
endpackage

// >>> tb/das_mem_model.sv
// Data memory array model behind the access block
`timescale 1ns/10ps
`default_nettype none
module das_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_re,
    input  wire logic        mem_we_lo,
    input  wire logic        mem_we_hi,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    output logic             mem_hit,
    input  wire logic [15:0] ymem_addr,
    input  wire logic        ymem_re,
    output logic      [15:0] ymem_rdata,
    output logic             ymem_hit
);
    logic [15:0] ram [0:1023];
    logic [15:0] junk_reg = 16'h5a3c;
    // ----
    // Array
    // ----
    // Words exist at 0x0800-0x0fff only; off the array the bus shows a moving pattern,
    // so a block that forgets to zero an unimplemented read is caught
    assign mem_hit = mem_addr[15:11] == 5'h01;
    assign ymem_hit = ymem_addr[15:11] == 5'h01;
    assign mem_rdata = (mem_hit && mem_re) ? ram[mem_addr[10:1]] : junk_reg;
    assign ymem_rdata = (ymem_hit && ymem_re) ? ram[ymem_addr[10:1]] : junk_reg;
    always_ff @(posedge ref_clk) begin
        junk_reg <= {junk_reg[14:0], ~junk_reg[15]};
        if (mem_hit && mem_we_lo) begin
            ram[mem_addr[10:1]][7:0] <= mem_wdata[7:0];
        end
        if (mem_hit && mem_we_hi) begin
            ram[mem_addr[10:1]][15:8] <= mem_wdata[15:8];
        end
    end
endmodule
`default_nettype wire

// >>> tb/das_core_chk.sv
// Port checker for the data access, alignment and stack check block
`timescale 1ns/10ps
`default_nettype none
module das_core_chk (
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic                acc_valid,
    input wire das_pkg::das_mode_t  acc_mode,
    input wire logic                acc_write,
    input wire logic                acc_byte,
    input wire logic [15:0]         acc_direct_addr,
    input wire logic                y_valid,
    input wire logic [15:0]         ymem_rdata,
    input wire logic                ymem_hit,
    input wire logic [15:0]         mem_addr,
    input wire logic                mem_re,
    input wire logic                mem_we_lo,
    input wire logic                mem_we_hi,
    input wire logic                x_rvalid,
    input wire logic [15:0]         y_rdata,
    input wire logic                y_rvalid,
    input wire logic [15:0]         effective_address,
    input wire logic [15:0]         stack_pointer,
    input wire logic                trap_req,
    input wire das_pkg::das_cause_t trap_cause
);
    import das_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----
    // Properties
    // ----
    AST_BYTE_LANE: assert property (acc_valid && acc_write && acc_byte &&
        acc_mode inside {das_mode_indirect, das_mode_near, das_mode_move} |->
        !(mem_we_hi && !effective_address[0]) && !(mem_we_lo && effective_address[0]))
        else $error("byte write strobed the wrong lane");
    AST_ODD_TRAP: assert property (acc_valid && !acc_byte && effective_address[0]
        |=> trap_req && trap_cause == das_cause_addr) else $error("odd word access did not trap");
    AST_ODD_RD: assert property (acc_valid && !acc_write && !acc_byte &&
        effective_address[0] |-> mem_re ##1 x_rvalid) else $error("odd read not completed");
    AST_ODD_WR: assert property (acc_valid && acc_write && !acc_byte &&
        effective_address[0] |-> !mem_we_lo && !mem_we_hi) else $error("odd write not suppressed");
    AST_NEAR: assert property (acc_valid && acc_mode == das_mode_near |->
        effective_address == (acc_direct_addr & 16'h1fff)) else $error("near address not 13 bits");
    AST_MOVE: assert property (acc_valid && acc_mode == das_mode_move |->
        effective_address == acc_direct_addr) else $error("move address not 16 bits");
    AST_PUSH: assert property (acc_valid && acc_mode == das_mode_push |->
        mem_addr == stack_pointer && mem_we_lo && mem_we_hi ##1
        stack_pointer == $past(stack_pointer) + 16'h0002) else $error("push order wrong");
    AST_POP: assert property (acc_valid && acc_mode == das_mode_pop |->
        effective_address == stack_pointer - 16'h0002 && mem_re ##1
        x_rvalid && stack_pointer == $past(stack_pointer) - 16'h0002) else $error("pop order wrong");
    AST_FLOOR: assert property (acc_valid && effective_address < 16'h0800 &&
        acc_mode inside {das_mode_push, das_mode_pop} |=> trap_req && trap_cause == das_cause_stack)
        else $error("stack underflow not trapped");
    AST_Y_WORD: assert property (y_valid |=> y_rvalid &&
        y_rdata == ($past(ymem_hit) ? $past(ymem_rdata) : 16'h0000)) else $error("Y word wrong");
    AST_TRAP_ONE: assert property (trap_req |-> $past(acc_valid) &&
        trap_cause != das_cause_none) else $error("trap without access or cause");
endmodule
bind das_core das_core_chk i_das_core_chk (.*);
`default_nettype wire

// >>> tb/das_core_tb_top.sv
// Self-checking testbench for the data access, alignment and stack check block
`timescale 1ns/10ps
`default_nettype none
module das_core_tb_top;
    import das_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0;
    logic        acc_byte = 1'b0, acc_post_inc = 1'b0, acc_pre_dec = 1'b0, acc_load = 1'b0;
    logic        ext_valid = 1'b0, sign_extend_op = 1'b0, y_valid = 1'b0;
    das_mode_t   acc_mode = das_mode_indirect;
    das_pcpush_t acc_pc_push = das_pcpush_none;
    logic [3:0]  acc_ptr_sel = 4'h0, acc_dest_sel = 4'h0, ext_reg_sel = 4'h0, y_ptr_sel = 4'h0;
    logic [15:0] acc_direct_addr = 16'h0000, acc_wdata = 16'h0000;
    logic [6:0]  pc_upper = 7'h00;
    logic [7:0]  status_low_byte = 8'h00;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, ymem_addr, ymem_rdata, x_rdata, y_rdata;
    logic [15:0] effective_address, stack_pointer;
    logic        mem_re, mem_we_lo, mem_we_hi, mem_hit, ymem_re, ymem_hit;
    logic        x_rvalid, y_rvalid, trap_req;
    das_cause_t  trap_cause;
    int          err_count = 0, checked = 0;
    das_core i_das_core (.*);
    das_mem_model i_das_mem_model (.*);
    always #25 ref_clk = ~ref_clk;
    // ----
    // Shared tasks
    // ----
    task automatic cmp(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One request, then a gap cycle, so no two requests ever sit back to back
    task automatic acc(input das_mode_t m, input logic w, b, input logic [15:0] a, d);
        @(posedge ref_clk);
        acc_mode <= m;
        acc_write <= w;
        acc_byte <= b;
        acc_direct_addr <= a;
        acc_wdata <= d;
        acc_valid <= 1'b1;
        @(posedge ref_clk);
        acc_valid <= 1'b0;
        acc_post_inc <= 1'b0;
        acc_load <= 1'b0;
        acc_pc_push <= das_pcpush_none;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, exp);
        acc(das_mode_move, 1'b0, 1'b0, a, 16'h0000);
        cmp(x_rdata, exp);
    endtask
    task automatic wr(input logic [15:0] a, d);
        acc(das_mode_move, 1'b1, 1'b0, a, d);
    endtask
    task automatic trap(input logic [15:0] exp);
        cmp({13'h0000, trap_req, trap_cause}, exp);
    endtask
    task automatic ext(input logic s);
        @(posedge ref_clk);
        ext_valid <= 1'b1;
        sign_extend_op <= s;
        ext_reg_sel <= 4'ha;
        @(posedge ref_clk);
        ext_valid <= 1'b0;
        #1;
    endtask
    task automatic yrd(input logic [15:0] exp);
        @(posedge ref_clk);
        y_valid <= 1'b1;
        y_ptr_sel <= 4'h8;
        @(posedge ref_clk);
        y_valid <= 1'b0;
        #1;
        cmp(y_rdata, exp);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        logic [15:0] ofs [13] = '{16'h0000, 16'h0004, 16'h000a, 16'h0010, 16'h0012, 16'h0014,
            16'h0016, 16'h0018, 16'h001a, 16'h3000, 16'h8000, 16'h9000, 16'hd000};
        cmp(stack_pointer, 16'h0800);
        foreach (ofs[i]) begin
            rd(ofs[i], 16'h0000);
        end
        wr(16'h0012, 16'h1234);
        rd(16'h0012, 16'h1234);
    endtask
    task automatic t_lanes;
        wr(16'h0900, 16'ha1b2);
        acc(das_mode_move, 1'b1, 1'b1, 16'h0901, 16'h335c);
        rd(16'h0900, 16'h5cb2);
        acc(das_mode_move, 1'b0, 1'b1, 16'h0901, 16'h0000);
        cmp(x_rdata, 16'h005c);
        acc(das_mode_move, 1'b0, 1'b1, 16'h0900, 16'h0000);
        cmp(x_rdata, 16'h00b2);
    endtask
    task automatic t_postinc;
        wr(16'h0010, 16'h0900);
        @(posedge ref_clk);
        acc_ptr_sel <= 4'h8;
        acc_post_inc <= 1'b1;
        acc(das_mode_indirect, 1'b0, 1'b1, 16'h0000, 16'h0000);
        rd(16'h0010, 16'h0901);
        wr(16'h0010, 16'h0900);
        @(posedge ref_clk);
        acc_post_inc <= 1'b1;
        acc(das_mode_indirect, 1'b0, 1'b0, 16'h0000, 16'h0000);
        cmp(x_rdata, 16'h5cb2);
        rd(16'h0010, 16'h0902);
    endtask
    task automatic t_misalign;
        wr(16'h0902, 16'h7777);
        acc(das_mode_move, 1'b1, 1'b0, 16'h0903, 16'h1111);
        trap(16'h0005);
        rd(16'h0902, 16'h7777);
        acc(das_mode_move, 1'b0, 1'b0, 16'h0901, 16'h0000);
        trap(16'h0005);
    endtask
    task automatic t_ldext;
        wr(16'h0014, 16'habcd);
        @(posedge ref_clk);
        acc_load <= 1'b1;
        acc_dest_sel <= 4'ha;
        acc(das_mode_move, 1'b0, 1'b1, 16'h0900, 16'h0000);
        rd(16'h0014, 16'habb2);
        ext(1'b1);
        rd(16'h0014, 16'hffb2);
        ext(1'b0);
        rd(16'h0014, 16'h00b2);
    endtask
    task automatic t_direct;
        acc(das_mode_near, 1'b0, 1'b0, 16'h2900, 16'h0000);
        cmp(x_rdata, 16'h5cb2);
        rd(16'h4900, 16'h0000);
        yrd(16'h7777);
        wr(16'h0010, 16'h0101);
        yrd(16'h0000);
    endtask
    task automatic t_stack;
        wr(16'h0020, 16'h0805);
        wr(16'h001e, 16'h0800);
        @(posedge ref_clk);
        acc_pc_push <= das_pcpush_call;
        pc_upper <= 7'h55;
        status_low_byte <= 8'hc3;
        acc(das_mode_push, 1'b1, 1'b0, 16'h0000, 16'hffff);
        cmp(stack_pointer, 16'h0802);
        @(posedge ref_clk);
        acc_pc_push <= das_pcpush_excp;
        pc_upper <= 7'h12;
        acc(das_mode_push, 1'b1, 1'b0, 16'h0000, 16'hffff);
        acc(das_mode_push, 1'b1, 1'b0, 16'h0000, 16'h4242);
        trap(16'h0000);
        acc(das_mode_push, 1'b1, 1'b0, 16'h0000, 16'h4343);
        trap(16'h0006);
        acc(das_mode_pop, 1'b0, 1'b0, 16'h0000, 16'h0000);
        cmp(x_rdata, 16'h4343);
        acc(das_mode_pop, 1'b0, 1'b0, 16'h0000, 16'h0000);
        acc(das_mode_pop, 1'b0, 1'b0, 16'h0000, 16'h0000);
        cmp(x_rdata, 16'hc312);
        acc(das_mode_pop, 1'b0, 1'b0, 16'h0000, 16'h0000);
        cmp(x_rdata, 16'h0055);
        acc(das_mode_pop, 1'b0, 1'b0, 16'h0000, 16'h0000);
        trap(16'h0006);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_lanes;
        t_postinc;
        t_misalign;
        t_ldext;
        t_direct;
        t_stack;
        wrap_up;
    end
    // Whole run needs some 130 cycles; about fifteen times that means a hang
    initial begin
        #(50 * 2000);
        err_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
